// [dv/reset_source_combiner_asserts.sv]
`timescale 1ns/1ps
module reset_source_combiner_asserts
    import reset_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Sources and configuration
    input wire logic masterClearPinN,
    input wire logic brownoutDetect,
    input wire logic softwareResetReq,
    input wire logic watchdogTimeout,
    input wire logic configMismatch,
    input wire logic trapConflict,
    input wire logic illegalOpcode,
    input wire logic uninitWRegAccess,
    input wire logic securityViolation,
    input wire logic [2:0] initialOscSelect,
    input wire logic watchdogEnableFuse,
    input wire logic [15:0] oscillatorControl,
    // Outputs under watch
    input wire logic masterSystemReset,
    input wire logic coldReset,
    input wire logic [2:0] resetOscSelect,
    input wire logic watchdogEnable,
    input wire logic regulatorStandbySelect,
    input wire logic flashRegulatorStandbySelect
);
    logic onChip, pinQuiet, wrCause;
    logic [2:0] curOsc;
    logic [1:0] stbyBits;
    logic [7:0] quietCnt_reg, quietCnt_next;
    assign onChip = softwareResetReq | watchdogTimeout | configMismatch | trapConflict
        | illegalOpcode | uninitWRegAccess | securityViolation;
    assign pinQuiet = masterClearPinN & ~brownoutDetect;
    assign wrCause = hsel & htrans[1] & hready & hwrite & (haddr[11:0] == CAUSE_OFF);
    assign curOsc = oscillatorControl[14:12];
    assign stbyBits = {hwdata[11], hwdata[8]};
    // Saturates so long idle runs never wrap back under the limit
    always_comb begin
        quietCnt_next = quietCnt_reg;
        if (onChip || !pinQuiet) begin
            quietCnt_next = 8'h00;
        end else if (quietCnt_reg != 8'hff) begin
            quietCnt_next = quietCnt_reg + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            quietCnt_reg <= 8'h00;
        end else begin
            quietCnt_reg <= quietCnt_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_src_reset;
        onChip |=> masterSystemReset [*2];
    endproperty
    a_src_reset: assert property (p_src_reset)
        else $error("Source did not hold system reset");
    property p_release;
        quietCnt_reg > 8'(STRETCH_CYCLES + 6) |-> !masterSystemReset;
    endproperty
    a_release: assert property (p_release)
        else $error("System reset stuck after sources dropped");
    property p_warm_osc;
        (!masterSystemReset && onChip && !brownoutDetect && !$past(brownoutDetect)
            && !$past(brownoutDetect, 2)) |=> (!coldReset && resetOscSelect == $past(curOsc));
    endproperty
    a_warm_osc: assert property (p_warm_osc)
        else $error("Warm reset did not keep current oscillator");
    // Two sync stages plus the select register put the cold choice three edges out
    property p_cold;
        brownoutDetect |-> ##3 (coldReset && resetOscSelect == initialOscSelect);
    endproperty
    a_cold: assert property (p_cold)
        else $error("Brown-out did not select configured oscillator");
    property p_sw_write;
        wrCause |-> ##2 ({flashRegulatorStandbySelect, regulatorStandbySelect}
            == $past(stbyBits));
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("Status write not stored");
    property p_no_sw_reset;
        (!masterSystemReset && wrCause && !onChip && pinQuiet && $past(pinQuiet)
            && $past(pinQuiet, 2)) ##1 (!onChip && pinQuiet) [*2] |=> !masterSystemReset;
    endproperty
    a_no_sw_reset: assert property (p_no_sw_reset)
        else $error("Status write caused a reset");
    property p_wdt_fuse;
        watchdogEnableFuse |-> watchdogEnable;
    endproperty
    a_wdt_fuse: assert property (p_wdt_fuse)
        else $error("Fuse did not force watchdog on");
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("Bus answer not ready and okay");
endmodule
bind reset_source_combiner reset_source_combiner_asserts #(
    .STRETCH_CYCLES(STRETCH_CYCLES)
) chk_u (.*);

// [dv/reset_source_combiner_bench.sv]
`timescale 1ns/1ps
module reset_source_combiner_bench;
    import reset_pkg::*;
    localparam int unsigned STRETCH = 2;
    localparam int BIT_TAB [11] = '{7, 1, 6, 4,
        9, 15, 14, 14, 14, 3, 2};
    logic clk, nrst, hsel, hwrite, hreadyout, hresp, irq, srcGo, fuse;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize, holdLen, initOsc, resetOscSelect;
    logic [3:0] srcSel;
    logic [15:0] oscCtl;
    logic pinN, bo, software_reset_flag, wdt, cfg, trap, ill, uninit, sec, slp, idl;
    logic msr, coldReset, wdtEn, stby, fstby;
    int mismatches = 0;
    int numChecks = 0;
    reset_source_combiner #(.STRETCH_CYCLES(STRETCH)) dut_u (.clk(clk), .nrst(nrst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .irq(irq), .masterClearPinN(pinN), .brownoutDetect(bo),
        .softwareResetReq(software_reset_flag), .watchdogTimeout(wdt), .configMismatch(cfg),
        .trapConflict(trap), .illegalOpcode(ill), .uninitWRegAccess(uninit),
        .securityViolation(sec), .sleepMode(slp), .idleMode(idl),
        .initialOscSelect(initOsc), .watchdogEnableFuse(fuse), .oscillatorControl(oscCtl),
        .masterSystemReset(msr), .coldReset(coldReset), .resetOscSelect(resetOscSelect),
        .watchdogEnable(wdtEn), .regulatorStandbySelect(stby),
        .flashRegulatorStandbySelect(fstby));
    reset_source_model src_u (.clk(clk), .nrst(nrst), .srcGo(srcGo), .srcSel(srcSel),
        .holdLen(holdLen), .masterClearPinN(pinN), .brownoutDetect(bo),
        .softwareResetReq(software_reset_flag), .watchdogTimeout(wdt), .configMismatch(cfg),
        .trapConflict(trap), .illegalOpcode(ill), .uninitWRegAccess(uninit),
        .securityViolation(sec), .sleepMode(slp), .idleMode(idl));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Bounded wait on a level; a hang ends the run
    task automatic wait_for(input logic want, input bit onReset);
        int n;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if ((onReset ? msr : hreadyout) === want) break;
        end
        if (n >= 100) begin
            mismatches++;
            finish_test();
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= wr;
        wait_for(1'b1, 1'b0);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_for(1'b1, 1'b0);
        rd = hrdata;
    endtask
    task automatic rd_check(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        check(what, d, exp);
    endtask
    // Combinational output: look once the edge's updates have landed
    task automatic irq_check(input logic exp);
        @(negedge clk);
        check("irq", {31'h0, irq}, {31'h0, exp});
        @(posedge clk);
    endtask
    task automatic fire(input int i);
        oscCtl <= 16'($urandom);
        srcSel <= 4'(i);
        holdLen <= 3'($urandom_range(4, 1));
        srcGo <= 1'b1;
        @(posedge clk);
        srcGo <= 1'b0;
        repeat (10) @(posedge clk);
        wait_for(1'b0, 1'b1);
    endtask
    function automatic logic [31:0] exp_cause(input int i);
        exp_cause = 32'h1 << BIT_TAB[i];
        // Only a system reset clears the soft watchdog enable
        if (i > 8) begin
            exp_cause = exp_cause | 32'h20;
        end
    endfunction
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        logic [31:0] d;
        logic [15:0] m;
        r = $urandom(32'h02e0);
        {nrst, hsel, hwrite, srcGo, fuse} = 5'h0;
        {haddr, hwdata, htrans, srcSel, oscCtl} = '0;
        hsize = 3'h2;
        holdLen = 3'h1;
        initOsc = 3'($urandom);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        wait_for(1'b0, 1'b1);
        rd_check("cause", CAUSE_OFF, 32'h3);
        rd_check("oscsel", OSC_SEL_OFF, {28'h0, 1'b1, initOsc});
        rd_check("irqstat", IRQ_STATUS_OFF, 32'h0);
        for (int k = 0; k < 6; k++) begin
            d = $urandom;
            fuse <= 1'($urandom);
            bus(1'b1, CAUSE_OFF, d, r);
            rd_check("cause", CAUSE_OFF, {16'h0, d[15:0] & CAUSE_WRITABLE});
            check("sysreset", {31'h0, msr}, 32'h0);
            check("wdten", {31'h0, wdtEn}, {31'h0, fuse | d[5]});
        end
        bus(1'b1, 12'h010, 32'hffff_ffff, r);
        rd_check("unmapped", 12'h010, 32'h0);
        for (int i = 0; i < 11; i++) begin
            m = 16'($urandom) & EVENT_BITS;
            bus(1'b1, CAUSE_OFF, 32'h20, r);
            bus(1'b1, IRQ_MASK_OFF, {16'h0, m}, r);
            fire(i);
            rd_check("cause", CAUSE_OFF, exp_cause(i));
            rd_check("irqstat", IRQ_STATUS_OFF, 32'h1 << BIT_TAB[i]);
            rd_check("irqclear", IRQ_STATUS_OFF, 32'h0);
            rd_check("mask", IRQ_MASK_OFF, (i > 8) ? {16'h0, m} : 32'h0);
            if (i < 9) begin
                check("cold", {31'h0, coldReset}, {31'h0, i == 1});
                check("osc", {29'h0, resetOscSelect},
                    {29'h0, (i == 1) ? initOsc : oscCtl[14:12]});
            end
        end
        bus(1'b1, IRQ_MASK_OFF, 32'h8, r);
        fire(9);
        irq_check(1'b1);
        rd_check("irqstat", IRQ_STATUS_OFF, 32'h8);
        irq_check(1'b0);
        fire(10);
        irq_check(1'b0);
        finish_test();
    end
endmodule

// [dv/reset_source_model.sv]
`timescale 1ns/1ps
module reset_source_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Command from the bench
    input wire logic srcGo,
    input wire logic [3:0] srcSel,
    input wire logic [2:0] holdLen,
    // Source levels toward the combiner
    output logic masterClearPinN,
    output logic brownoutDetect,
    output logic softwareResetReq,
    output logic watchdogTimeout,
    output logic configMismatch,
    output logic trapConflict,
    output logic illegalOpcode,
    output logic uninitWRegAccess,
    output logic securityViolation,
    output logic sleepMode,
    output logic idleMode
);
    logic [2:0] cnt_reg, cnt_next;
    logic [3:0] sel_reg, sel_next;
    logic [10:0] act;
    always_comb begin
        cnt_next = cnt_reg;
        sel_next = sel_reg;
        if (srcGo) begin
            cnt_next = holdLen;
            sel_next = srcSel;
        end else if (cnt_reg != 3'h0) begin
            cnt_next = cnt_reg - 3'h1;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 3'h0;
            sel_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
            sel_reg <= sel_next;
        end
    end
    // One source at a time, so each flag is seen alone
    assign act = (cnt_reg != 3'h0) ? (11'h001 << sel_reg) : 11'h000;
    // Pin idles high, as its pull-up would hold it
    assign masterClearPinN = ~act[0];
    assign brownoutDetect = act[1];
    assign softwareResetReq = act[2];
    assign watchdogTimeout = act[3];
    assign configMismatch = act[4];
    assign trapConflict = act[5];
    assign illegalOpcode = act[6];
    assign uninitWRegAccess = act[7];
    assign securityViolation = act[8];
    assign sleepMode = act[9];
    assign idleMode = act[10];
endmodule

// [rtl/reset_pkg.sv]
package reset_pkg;

    // Clock and reset stretch timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RESET_STRETCH_NS = 100;
    localparam int unsigned RESET_STRETCH_CYCLES =
        (RESET_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STRETCH_CNT_W = 8;

    // Register byte offsets
    localparam logic [11:0] CAUSE_OFF = 12'h000;
    localparam logic [11:0] IRQ_STATUS_OFF = 12'h004;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h008;
    localparam logic [11:0] OSC_SEL_OFF = 12'h00c;

    // Reset cause status field positions
    localparam int unsigned BIT_POWER_ON = 0;
    localparam int unsigned BIT_BROWNOUT = 1;
    localparam int unsigned BIT_IDLE_WAKE = 2;
    localparam int unsigned BIT_SLEEP_WAKE = 3;
    localparam int unsigned BIT_WATCHDOG = 4;
    localparam int unsigned BIT_SOFT_WD_EN = 5;
    localparam int unsigned BIT_SOFTWARE = 6;
    localparam int unsigned BIT_EXT_PIN = 7;
    localparam int unsigned BIT_REG_STANDBY = 8;
    localparam int unsigned BIT_CFG_MISMATCH = 9;
    localparam int unsigned BIT_FLASH_STANDBY = 11;
    localparam int unsigned BIT_ILLEGAL = 14;
    localparam int unsigned BIT_TRAP = 15;

    // Reset values and masks
    localparam logic [15:0] CAUSE_RESET = 16'h0003;
    localparam logic [15:0] CAUSE_WRITABLE = 16'hcbff;
    localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
    localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
    localparam logic [15:0] EVENT_BITS = 16'hc2df;
    localparam logic [2:0] OSC_SEL_RESET = 3'h0;

    // Current oscillator field in oscillator control
    localparam int unsigned OSC_CUR_LSB = 12;
    localparam int unsigned OSC_CUR_MSB = 14;

    typedef struct packed {
        logic trapConflict;
        logic illegalCondition;
        logic configMismatch;
        logic masterClear;
        logic softwareReset;
        logic watchdogTimeout;
        logic brownout;
    } reset_src_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } ahb_cmd_s;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_HOLD = 3'b010,
        ST_STRETCH = 3'b100
    } seq_state_e;

endpackage

// [rtl/reset_source_combiner.sv]
// Notes on behaviour
// - Any active source asserts master system reset.
// - System reset clears chosen registers, keeps others.
// - Each reset type sets its own flag.
// - Power-on leaves only bits 1:0 set.
// - Software may set or clear any bit; here bits 10, 12 and 13 are not writable and stay 0.
// - Software flag writes never cause a reset.
// - Cold reset takes clock from config word.
// - Warm reset keeps current oscillator field 14:12.
// - Reset instruction is warm, sets bit 6.
// - Trap conflict reset sets bit 15.
// - Illegal opcode, W register, security set 14.
// - Configuration mismatch reset sets bit 9.
// - External clear pin reset sets bit 7.
// - Watchdog time-out reset sets bit 4.
// - Sleep sets bit 3, idle bit 2.
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module reset_source_combiner
    import reset_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = reset_pkg::RESET_STRETCH_CYCLES
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt
    output logic irq,
    // Pin-level sources, asynchronous
    input wire logic masterClearPinN,
    input wire logic brownoutDetect,
    // On-chip sources, same clock
    input wire logic softwareResetReq,
    input wire logic watchdogTimeout,
    input wire logic configMismatch,
    input wire logic trapConflict,
    input wire logic illegalOpcode,
    input wire logic uninitWRegAccess,
    input wire logic securityViolation,
    // Power-saving mode levels
    input wire logic sleepMode,
    input wire logic idleMode,
    // Configuration and oscillator state
    input wire logic [2:0] initialOscSelect,
    input wire logic watchdogEnableFuse,
    input wire logic [15:0] oscillatorControl,
    // Reset and clock control out
    output logic masterSystemReset,
    output logic coldReset,
    output logic [2:0] resetOscSelect,
    output logic watchdogEnable,
    output logic regulatorStandbySelect,
    output logic flashRegulatorStandbySelect
);
    import reset_pkg::*;

    localparam logic [STRETCH_CNT_W-1:0] STRETCH_LAST =
        STRETCH_CNT_W'(STRETCH_CYCLES - 1);

    // Pin synchronisers
    logic [1:0] pinSync;
    logic masterClearActive;
    logic brownoutActive;

    sync_bits #(
        .W(2),
        .RESET_VAL(2'h1)
    ) u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .asyncIn({brownoutDetect, masterClearPinN}),
        .syncOut(pinSync)
    );

    assign masterClearActive = ~pinSync[0];
    assign brownoutActive = pinSync[1];

    // Source collection
    reset_src_s src;
    logic anySource;

    always_comb begin
        src.trapConflict = trapConflict;
        src.illegalCondition = illegalOpcode | uninitWRegAccess | securityViolation;
        src.configMismatch = configMismatch;
        src.masterClear = masterClearActive;
        src.softwareReset = softwareResetReq;
        src.watchdogTimeout = watchdogTimeout;
        src.brownout = brownoutActive;
        anySource = |src;
    end

    // Reset sequencer: hold while a source is active, then stretch
    seq_state_e state_reg;
    seq_state_e state_next;
    logic [STRETCH_CNT_W-1:0] stretchCnt_reg;
    logic [STRETCH_CNT_W-1:0] stretchCnt_next;
    logic master_system_reset_reg;
    logic master_system_reset_next;

    always_comb begin
        state_next = state_reg;
        stretchCnt_next = stretchCnt_reg;
        case (state_reg)
            ST_RUN: begin
                if (anySource) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                stretchCnt_next = '0;
                if (!anySource) begin
                    state_next = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                if (anySource) begin
                    state_next = ST_HOLD;
                end else if (stretchCnt_reg >= STRETCH_LAST) begin
                    state_next = ST_RUN;
                end else begin
                    stretchCnt_next = stretchCnt_reg + STRETCH_CNT_W'(1);
                end
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
        master_system_reset_next = (state_next != ST_RUN);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_HOLD;
            stretchCnt_reg <= '0;
            master_system_reset_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            stretchCnt_reg <= stretchCnt_next;
            master_system_reset_reg <= master_system_reset_next;
        end
    end

    assign masterSystemReset = master_system_reset_reg;

    // Cold or warm clock source choice
    logic coldPending_reg;
    logic coldPending_next;
    logic coldReset_reg;
    logic coldReset_next;
    logic [2:0] oscSel_reg;
    logic [2:0] oscSel_next;
    logic warmEntry;

    // Config word is only sampled after release, never under the async reset
    always_comb begin
        coldPending_next = 1'b0;
        coldReset_next = coldReset_reg;
        oscSel_next = oscSel_reg;
        warmEntry = (state_reg == ST_RUN) && anySource && !brownoutActive;
        if (coldPending_reg || brownoutActive) begin
            coldReset_next = 1'b1;
            oscSel_next = initialOscSelect;
        end else if (warmEntry) begin
            coldReset_next = 1'b0;
            oscSel_next = oscillatorControl[OSC_CUR_MSB:OSC_CUR_LSB];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coldPending_reg <= 1'b1;
            coldReset_reg <= 1'b1;
            oscSel_reg <= OSC_SEL_RESET;
        end else begin
            coldPending_reg <= coldPending_next;
            coldReset_reg <= coldReset_next;
            oscSel_reg <= oscSel_next;
        end
    end

    assign coldReset = coldReset_reg;
    assign resetOscSelect = oscSel_reg;

    // Wake-up detection on leaving a power-saving mode
    logic sleepPrev_reg;
    logic idlePrev_reg;
    logic sleepPrev_next;
    logic idlePrev_next;
    logic sleepWake;
    logic idleWake;

    always_comb begin
        sleepPrev_next = sleepMode;
        idlePrev_next = idleMode;
        sleepWake = sleepPrev_reg & ~sleepMode;
        idleWake = idlePrev_reg & ~idleMode;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleepPrev_reg <= 1'b0;
            idlePrev_reg <= 1'b0;
        end else begin
            sleepPrev_reg <= sleepPrev_next;
            idlePrev_reg <= idlePrev_next;
        end
    end

    // AHB-Lite address phase capture
    ahb_cmd_s cmd_reg;
    ahb_cmd_s cmd_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic addrPhase;
    logic [15:0] causeFlags;
    logic [15:0] irqFlags;
    logic [15:0] irqMask_reg;
    logic [15:0] irqMask_next;
    logic readIrqStatus;

    assign addrPhase = hsel && htrans[1] && hready;

    // Read data is registered at the address phase, so a read-clear acts there
    always_comb begin
        cmd_next.valid = addrPhase;
        cmd_next.write = hwrite;
        cmd_next.addr = haddr[11:0];
        rdata_next = rdata_reg;
        readIrqStatus = 1'b0;
        if (addrPhase && !hwrite) begin
            if (haddr[11:0] == CAUSE_OFF) begin
                rdata_next = {16'h0000, causeFlags & CAUSE_WRITABLE};
            end else if (haddr[11:0] == IRQ_STATUS_OFF) begin
                rdata_next = {16'h0000, irqFlags};
                readIrqStatus = 1'b1;
            end else if (haddr[11:0] == IRQ_MASK_OFF) begin
                rdata_next = {16'h0000, irqMask_reg};
            end else if (haddr[11:0] == OSC_SEL_OFF) begin
                rdata_next = {28'h0000000, coldReset_reg, oscSel_reg};
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_reg <= '0;
            rdata_reg <= 32'h00000000;
        end else begin
            cmd_reg <= cmd_next;
            rdata_reg <= rdata_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    // Reset cause status register
    logic causeWrite;
    logic [15:0] causeSet;
    logic [15:0] causeWrData;
    logic [15:0] causeClr;

    always_comb begin
        causeWrite = cmd_reg.valid && cmd_reg.write && (cmd_reg.addr == CAUSE_OFF);
        // Only stored status changes; nothing here reaches the sequencer
        causeWrData = (hwdata[15:0] & CAUSE_WRITABLE) | (causeFlags & ~CAUSE_WRITABLE);
        causeSet = 16'h0000;
        causeSet[BIT_BROWNOUT] = src.brownout;
        causeSet[BIT_WATCHDOG] = src.watchdogTimeout;
        causeSet[BIT_SOFTWARE] = src.softwareReset;
        causeSet[BIT_EXT_PIN] = src.masterClear;
        causeSet[BIT_CFG_MISMATCH] = src.configMismatch;
        causeSet[BIT_ILLEGAL] = src.illegalCondition;
        causeSet[BIT_TRAP] = src.trapConflict;
        causeSet[BIT_SLEEP_WAKE] = sleepWake;
        causeSet[BIT_IDLE_WAKE] = idleWake;
        // Software watchdog enable is the one bit that system reset clears
        causeClr = 16'h0000;
        causeClr[BIT_SOFT_WD_EN] = master_system_reset_reg;
    end

    // Flags sit on the power-on reset; the system reset clears only the software watchdog enable
    sticky_flags #(
        .W(16),
        .RESET_VAL(CAUSE_RESET)
    ) u_cause (
        .clk(clk),
        .nrst(nrst),
        .setBits(causeSet & CAUSE_WRITABLE),
        .wrEn(causeWrite),
        .wrData(causeWrData),
        .clrBits(causeClr),
        .flags(causeFlags)
    );

    // Interrupt status, cleared by a read
    sticky_flags #(
        .W(16),
        .RESET_VAL(IRQ_STATUS_RESET)
    ) u_irq_status (
        .clk(clk),
        .nrst(nrst),
        .setBits(causeSet & EVENT_BITS),
        .wrEn(1'b0),
        .wrData(16'h0000),
        .clrBits({16{readIrqStatus}}),
        .flags(irqFlags)
    );

    // Interrupt mask, in the system-reset subset
    always_comb begin
        irqMask_next = irqMask_reg;
        if (master_system_reset_reg) begin
            irqMask_next = IRQ_MASK_RESET;
        end else if (cmd_reg.valid && cmd_reg.write && (cmd_reg.addr == IRQ_MASK_OFF)) begin
            irqMask_next = hwdata[15:0] & EVENT_BITS;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqMask_reg <= IRQ_MASK_RESET;
        end else begin
            irqMask_reg <= irqMask_next;
        end
    end

    assign irq = |(irqFlags & irqMask_reg);

    // Control bits held in the status word
    assign watchdogEnable = watchdogEnableFuse | causeFlags[BIT_SOFT_WD_EN];
    assign regulatorStandbySelect = causeFlags[BIT_REG_STANDBY];
    assign flashRegulatorStandbySelect = causeFlags[BIT_FLASH_STANDBY];

endmodule

// [rtl/sticky_flags.sv]
`timescale 1ns/1ps
module sticky_flags #(
    parameter int W = 16,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Hardware sets, software writes or clears
    input wire logic [W-1:0] setBits,
    input wire logic wrEn,
    input wire logic [W-1:0] wrData,
    input wire logic [W-1:0] clrBits,
    output logic [W-1:0] flags
);
    logic [W-1:0] flags_reg;
    logic [W-1:0] flags_next;

    // Set is applied last so an event never loses to a clear
    always_comb begin
        flags_next = wrEn ? wrData : (flags_reg & ~clrBits);
        flags_next = flags_next | setBits;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= RESET_VAL;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule

// [rtl/sync_bits.sv]
`timescale 1ns/1ps
module sync_bits #(
    parameter int W = 2,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic stage1_reg;
            logic stage2_reg;
            logic stage1_next;
            logic stage2_next;
            // First stage feeds only the second stage
            always_comb begin
                stage1_next = asyncIn[i];
                stage2_next = stage1_reg;
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    stage1_reg <= RESET_VAL[i];
                    stage2_reg <= RESET_VAL[i];
                end else begin
                    stage1_reg <= stage1_next;
                    stage2_reg <= stage2_next;
                end
            end
            assign syncOut[i] = stage2_reg;
        end
    endgenerate
endmodule
